// File: edrx_pkg.sv
// Register map, field layout, reset values and timing constants of the energy-detect block
package edrx_pkg;
    localparam logic [7:0] ADDR_RX_CTRL = 8'h15;
    localparam logic [7:0] ADDR_CCA_CTRL = 8'h2f;
    localparam logic [7:0] ADDR_ED_CTRL = 8'h31;
    localparam logic [7:0] ADDR_ED_MEAN = 8'h32;
    localparam logic [7:0] ADDR_ED_PEAK = 8'h33;
    localparam logic [7:0] ADDR_RX_SIDE = 8'h34;
    // receive_control_one bits
    localparam int RX_EN_BIT = 7;
    localparam int NO_PARSE_BIT = 6;
    localparam int DECRYPT_BIT = 5;
    localparam int APP_LQI_BIT = 4;
    localparam int APP_SS_BIT = 3;
    localparam int APP_CFR_BIT = 2;
    localparam int APP_CFO_BIT = 1;
    // channel_assess_control bits
    localparam int CCA_BUSY_BIT = 7;
    localparam int CCA_START_BIT = 6;
    // energy_detect_control bits
    localparam int ED_MODE_BIT = 5;
    localparam int ED_START_BIT = 4;
    // Side status register bits
    localparam int SIDE_DONE_BIT = 0;
    localparam int SIDE_SUSPEND_BIT = 1;
    localparam int SIDE_RX_ACTIVE_BIT = 2;
    localparam logic [7:0] RX_CTRL_RESET = 8'h00;
    localparam logic [5:0] THRESH_RESET = 6'h0c;
    localparam logic [3:0] ED_LEN_RESET = 4'he;
    localparam int ATOM_SEQ_UNIT = 8;
    // Transceiver mode encodings
    localparam logic [1:0] MODE_PACKET = 2'h0;
    localparam logic [1:0] MODE_TX_STREAM = 2'h1;
    localparam logic [1:0] MODE_RX_STREAM = 2'h2;
    // Timing
    localparam int CLK_MHZ = 125;
    localparam int ATOM_TIME_US = 128;
    localparam int ATOM_CYCLES = ATOM_TIME_US * CLK_MHZ;
endpackage : edrx_pkg

// File: edrx_core.sv
// Energy detect, manual channel assessment and receive control register block
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
// Notes on behaviour
// - Clearing receive enable aborts packet in progress
// - TX streaming clears, RX streaming sets enable
// - CSMA assessment and ack receive force radio
// - Receive settings change only while disabled; the register takes writes at any time
// - No-parse skips parsing, keeps CRC check
// - Decrypt start self-clears when security done
// - Link quality append flag drives packet buffer
// - Signal strength append flag drives packet buffer
// - Append channel, format, rate, MSB first
// - Append frequency offset in measure encoding
// - Busy flag holds latest assessment outcome
// - Assessment start self-clears, sets done flag
// - Busy when mean upper six exceed threshold
// - Threshold resets to 001100, 2 dB steps
// - Reception stays active during manual assessment
// - Sampling mode: one 128 us peak measurement
// - Scan mode: length-driven, mean stored
// - Energy start self-clears; done flag untouched
// - Receive change or clear aborts measurement
// - Length M gives (M+1)*8 atomic measurements
// - Reception suspended during energy measurement
// - Atomic average of strength; peak keeps largest
// - Mean and peak are read-only, reset zero
module edrx_core #(
    parameter int ATOM_CYC = edrx_pkg::ATOM_CYCLES,
    parameter int SAMPLE_W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Analog receive chain
    input wire logic [SAMPLE_W-1:0] signal_strength,
    input wire logic signal_valid,
    // Receive side context
    input wire logic [1:0] transceiver_mode,
    input wire logic mode_write,
    input wire logic packet_arriving,
    input wire logic collision_avoid_enable,
    input wire logic csma_assess_active,
    input wire logic ack_wait_active,
    input wire logic decrypt_done,
    input wire logic decrypt_ok,
    // Receive side controls
    output logic radio_rx_on,
    output logic rx_abort,
    output logic rx_suspend,
    output logic no_parse,
    output logic append_link_quality,
    output logic append_signal_strength,
    output logic append_channel_format_rate,
    output logic append_freq_offset,
    output logic decrypt_start_pulse,
    output logic decrypt_done_flag_set,
    output logic auth_tag_flag_set,
    output logic measure_done_flag_set
);

    // Sums and averages are sized for samples of eight to sixteen bits
    if (ATOM_CYC < 1 || SAMPLE_W < 8 || SAMPLE_W > 16) begin : g_bad_params
        $error("edrx_core: unsupported parameter values");
    end

    typedef enum logic [1:0] {
        EDRX_IDLE = 2'b00,
        EDRX_ED = 2'b01,
        EDRX_CCA = 2'b10
    } edrx_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] rx_ctrl_reg;
    logic cca_busy_reg;
    logic cca_start_reg;
    logic [5:0] thresh_reg;
    logic ed_mode_reg;
    logic ed_start_reg;
    logic [3:0] ed_len_reg;
    logic [7:0] ed_mean_reg;
    logic [7:0] ed_peak_reg;
    logic done_sticky_reg;
    edrx_state_t state_reg;
    logic [7:0] rdata_reg;

    // Measurement datapath
    logic [$clog2(ATOM_CYC+1)-1:0] cyc_cnt_reg;
    logic [SAMPLE_W+$clog2(ATOM_CYC+1)-1:0] atom_sum_reg;
    logic [$clog2(ATOM_CYC+1)-1:0] atom_n_reg;
    logic [7:0] atom_cnt_reg;
    logic [15:0] seq_sum_reg;
    logic [7:0] seq_peak_reg;
    logic rx_en_prev_reg;

    // Decoded write strobes
    logic wr_rx, wr_cca, wr_ed;

    // Combinational measurement results
    logic atom_end;
    logic [7:0] atom_avg;
    logic [7:0] new_peak;
    logic [15:0] new_sum;
    logic [7:0] atoms_total;
    logic seq_end;
    logic ed_abort;

    // Clamp stops a large quotient wrapping small
    function automatic logic [7:0] sat8(input logic [31:0] v);
        sat8 = (v > 32'd255) ? 8'hff : v[7:0];
    endfunction : sat8

    assign wr_rx = reg_wr && (reg_addr == edrx_pkg::ADDR_RX_CTRL);
    assign wr_cca = reg_wr && (reg_addr == edrx_pkg::ADDR_CCA_CTRL);
    assign wr_ed = reg_wr && (reg_addr == edrx_pkg::ADDR_ED_CTRL);

    ////////////////////////////////////////////////////////////////////////////
    // Receive control register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_ctrl_reg <= edrx_pkg::RX_CTRL_RESET;
        end else begin
            if (wr_rx) begin
                // Reserved bit 0 stays zero; decrypt bit can only be set by software
                rx_ctrl_reg[7:6] <= reg_wdata[7:6];
                rx_ctrl_reg[4:1] <= reg_wdata[4:1];
                if (reg_wdata[edrx_pkg::DECRYPT_BIT]) begin
                    rx_ctrl_reg[edrx_pkg::DECRYPT_BIT] <= 1'b1;
                end
            end

            // A same-cycle set beats the clear
            if (decrypt_done && !(wr_rx && reg_wdata[edrx_pkg::DECRYPT_BIT])) begin
                rx_ctrl_reg[edrx_pkg::DECRYPT_BIT] <= 1'b0;
            end

            // Mode change takes precedence over a same-cycle software write
            if (mode_write && transceiver_mode == edrx_pkg::MODE_TX_STREAM) begin
                rx_ctrl_reg[edrx_pkg::RX_EN_BIT] <= 1'b0;
            end else if (mode_write && transceiver_mode == edrx_pkg::MODE_RX_STREAM) begin
                rx_ctrl_reg[edrx_pkg::RX_EN_BIT] <= 1'b1;
            end

            rx_ctrl_reg[0] <= 1'b0;
        end
    end

    // Delayed enable exposes its edges
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_en_prev_reg <= 1'b0;
        end else begin
            rx_en_prev_reg <= rx_ctrl_reg[edrx_pkg::RX_EN_BIT];
        end
    end

    // Abort only on a falling enable with a packet underway, in any receive mode
    assign rx_abort = rx_en_prev_reg && !rx_ctrl_reg[edrx_pkg::RX_EN_BIT] && packet_arriving;
    // Automatic receive windows override enable
    assign radio_rx_on = rx_ctrl_reg[edrx_pkg::RX_EN_BIT]
        || (collision_avoid_enable && csma_assess_active) || ack_wait_active;
    assign no_parse = rx_ctrl_reg[edrx_pkg::NO_PARSE_BIT];
    assign append_link_quality = rx_ctrl_reg[edrx_pkg::APP_LQI_BIT];
    assign append_signal_strength = rx_ctrl_reg[edrx_pkg::APP_SS_BIT];
    assign append_channel_format_rate = rx_ctrl_reg[edrx_pkg::APP_CFR_BIT];
    assign append_freq_offset = rx_ctrl_reg[edrx_pkg::APP_CFO_BIT];

    // No restart while processing runs
    assign decrypt_start_pulse = wr_rx && reg_wdata[edrx_pkg::DECRYPT_BIT]
        && !rx_ctrl_reg[edrx_pkg::DECRYPT_BIT];
    assign decrypt_done_flag_set = decrypt_done && rx_ctrl_reg[edrx_pkg::DECRYPT_BIT] && decrypt_ok;
    assign auth_tag_flag_set = decrypt_done && rx_ctrl_reg[edrx_pkg::DECRYPT_BIT] && !decrypt_ok;

    // Energy scan blanks the packet path; manual assessment does not
    assign rx_suspend = (state_reg == EDRX_ED);

    ////////////////////////////////////////////////////////////////////////////
    // Atomic measurement datapath
    // Atom spans ATOM_CYC cycles
    assign atom_end = (state_reg != EDRX_IDLE) && (cyc_cnt_reg == ($bits(cyc_cnt_reg))'(ATOM_CYC - 1));
    // Empty interval gives zero rather than a divide by zero
    assign atom_avg = (atom_n_reg == '0) ? 8'h00 : sat8(32'(atom_sum_reg / atom_n_reg));
    assign new_peak = (atom_cnt_reg == 8'h00 || atom_avg > seq_peak_reg) ? atom_avg : seq_peak_reg;
    // 128 full-scale atoms fit in 16 bits
    assign new_sum = seq_sum_reg + 16'(atom_avg);
    // Sampling mode and manual assessment use a single atom
    assign atoms_total = (state_reg == EDRX_ED && !ed_mode_reg)
        ? 8'((ed_len_reg + 8'd1) * edrx_pkg::ATOM_SEQ_UNIT) : 8'd1;
    // Ends on the last atom's closing edge
    assign seq_end = atom_end && (atom_cnt_reg + 8'd1 == atoms_total);
    // Any change of receive enable or software clearing the start bit abandons the scan
    assign ed_abort = (state_reg == EDRX_ED) && ((rx_en_prev_reg != rx_ctrl_reg[edrx_pkg::RX_EN_BIT])
        || (wr_ed && !reg_wdata[edrx_pkg::ED_START_BIT]));

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cyc_cnt_reg <= '0;
            atom_sum_reg <= '0;
            atom_n_reg <= '0;
        // Closing cycle's sample is not summed
        end else if (state_reg == EDRX_IDLE || atom_end) begin
            cyc_cnt_reg <= '0;
            atom_sum_reg <= '0;
            atom_n_reg <= '0;
        end else begin
            cyc_cnt_reg <= cyc_cnt_reg + 1'b1;
            if (signal_valid) begin
                atom_sum_reg <= atom_sum_reg + ($bits(atom_sum_reg))'(signal_strength);
                atom_n_reg <= atom_n_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            atom_cnt_reg <= 8'h00;
            seq_sum_reg <= 16'h0000;
            seq_peak_reg <= 8'h00;
        end else if (state_reg == EDRX_IDLE) begin
            atom_cnt_reg <= 8'h00;
            seq_sum_reg <= 16'h0000;
            seq_peak_reg <= 8'h00;
        // First atom seeds the peak
        end else if (atom_end) begin
            atom_cnt_reg <= atom_cnt_reg + 8'd1;
            seq_sum_reg <= new_sum;
            seq_peak_reg <= new_peak;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= EDRX_IDLE;
        end else begin
            case (state_reg)
                EDRX_IDLE: begin
                    // Starts are taken only here
                    if (wr_ed && reg_wdata[edrx_pkg::ED_START_BIT]) begin
                        state_reg <= EDRX_ED;
                    end else if (wr_cca && reg_wdata[edrx_pkg::CCA_START_BIT]) begin
                        state_reg <= EDRX_CCA;
                    end
                end
                EDRX_ED: begin
                    if (ed_abort || seq_end) begin
                        state_reg <= EDRX_IDLE;
                    end
                end
                EDRX_CCA: begin
                    if (seq_end) begin
                        state_reg <= EDRX_IDLE;
                    end
                end
                default: begin
                    // Unused code recovers to idle
                    state_reg <= EDRX_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assessment and energy control registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cca_busy_reg <= 1'b0;
            cca_start_reg <= 1'b0;
            thresh_reg <= edrx_pkg::THRESH_RESET;
        end else begin
            // New threshold applies at once
            if (wr_cca) begin
                thresh_reg <= reg_wdata[5:0];
            end

            // Start while busy is ignored
            if (state_reg == EDRX_IDLE && wr_cca && reg_wdata[edrx_pkg::CCA_START_BIT]
                && !(wr_ed && reg_wdata[edrx_pkg::ED_START_BIT])) begin
                cca_start_reg <= 1'b1;
            end else if (state_reg == EDRX_CCA && seq_end) begin
                cca_start_reg <= 1'b0;
                // Threshold is in 2 dB steps, so compare against mean bits 7:2
                cca_busy_reg <= (new_sum[7:2] > thresh_reg);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ed_mode_reg <= 1'b0;
            ed_start_reg <= 1'b0;
            ed_len_reg <= edrx_pkg::ED_LEN_RESET;
        end else begin
            // Mode and length take every write, even while a scan runs
            if (wr_ed) begin
                ed_mode_reg <= reg_wdata[edrx_pkg::ED_MODE_BIT];
                ed_len_reg <= reg_wdata[3:0];
            end

            if (state_reg == EDRX_IDLE && wr_ed && reg_wdata[edrx_pkg::ED_START_BIT]) begin
                ed_start_reg <= 1'b1;
            end else if (ed_abort || (state_reg == EDRX_ED && seq_end) || (wr_ed && state_reg == EDRX_IDLE)) begin
                ed_start_reg <= 1'b0;
            end
        end
    end

    // Mean and peak update together at a scan's end; sampling mode reports through the peak
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ed_mean_reg <= 8'h00;
            ed_peak_reg <= 8'h00;
        end else if (seq_end && state_reg == EDRX_ED) begin
            if (ed_mode_reg) begin
                ed_peak_reg <= atom_avg;
                ed_mean_reg <= atom_avg;
            end else begin
                ed_mean_reg <= sat8(32'(new_sum) / 32'(atoms_total));
                ed_peak_reg <= new_peak;
            end
        // Assessment keeps the last scan peak
        end else if (seq_end && state_reg == EDRX_CCA) begin
            ed_mean_reg <= atom_avg;
        end
    end

    // Completion flag is raised by assessment only; energy scan leaves it alone
    assign measure_done_flag_set = (state_reg == EDRX_CCA) && seq_end;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            done_sticky_reg <= 1'b0;
        // Set wins over a same-cycle read
        end else if (measure_done_flag_set) begin
            done_sticky_reg <= 1'b1;
        end else if (reg_rd && reg_addr == edrx_pkg::ADDR_RX_SIDE) begin
            done_sticky_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                edrx_pkg::ADDR_RX_CTRL: rdata_reg <= rx_ctrl_reg;
                edrx_pkg::ADDR_CCA_CTRL: rdata_reg <= {cca_busy_reg, cca_start_reg, thresh_reg};
                edrx_pkg::ADDR_ED_CTRL: rdata_reg <= {2'b00, ed_mode_reg, ed_start_reg, ed_len_reg};
                edrx_pkg::ADDR_ED_MEAN: rdata_reg <= ed_mean_reg;
                edrx_pkg::ADDR_ED_PEAK: rdata_reg <= ed_peak_reg;
                edrx_pkg::ADDR_RX_SIDE: rdata_reg <= {5'h00, radio_rx_on, rx_suspend, done_sticky_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    // Holds between reads
    assign reg_rdata = rdata_reg;

endmodule : edrx_core

// File: edrx_rf_model.sv
// Behavioural receive chain that feeds strength samples to the block
`timescale 1ns/1ns
module edrx_rf_model (
    // Clock
    input wire logic ref_clk,
    // Bench control
    input wire logic [7:0] level,
    input wire logic on,
    // Sample stream
    output logic [7:0] signal_strength,
    output logic signal_valid
);
    initial signal_strength = 8'h5a;
    initial signal_valid = 1'b0;
    // Off-air the line keeps toggling so a consumer that ignores valid averages garbage
    always @(posedge ref_clk) begin
        signal_valid <= on;
        signal_strength <= on ? level : ~signal_strength;
    end
endmodule : edrx_rf_model

// File: edrx_core_props.sv
// Concurrent port checks of the energy-detect block
`timescale 1ns/1ns
module edrx_core_props #(
    parameter int ATOM_CYC = 16000,
    parameter int SAMPLE_W = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Receive side context
    input wire logic [1:0] transceiver_mode,
    input wire logic mode_write,
    input wire logic packet_arriving,
    input wire logic collision_avoid_enable,
    input wire logic csma_assess_active,
    input wire logic ack_wait_active,
    input wire logic decrypt_done,
    input wire logic decrypt_ok,
    // Receive side controls
    input wire logic radio_rx_on,
    input wire logic rx_abort,
    input wire logic rx_suspend,
    input wire logic no_parse,
    input wire logic append_link_quality,
    input wire logic append_signal_strength,
    input wire logic append_channel_format_rate,
    input wire logic append_freq_offset,
    input wire logic decrypt_start_pulse,
    input wire logic decrypt_done_flag_set,
    input wire logic auth_tag_flag_set,
    input wire logic measure_done_flag_set
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    int unsigned susp_cnt;
    // Longest legal scan is sixteen groups of eight atoms
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            susp_cnt <= 0;
        end else begin
            susp_cnt <= rx_suspend ? susp_cnt + 1 : 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_abort; rx_abort |-> packet_arriving; endproperty
    a_abort: assert property (p_abort) else $error("abort without a frame arriving");
    property p_rx_stream; mode_write && transceiver_mode == edrx_pkg::MODE_RX_STREAM |=> radio_rx_on; endproperty
    a_rx_stream: assert property (p_rx_stream) else $error("receive streaming left radio off");
    property p_tx_stream;
        mode_write && transceiver_mode == edrx_pkg::MODE_TX_STREAM
            |=> radio_rx_on == (ack_wait_active || (collision_avoid_enable && csma_assess_active));
    endproperty
    a_tx_stream: assert property (p_tx_stream) else $error("transmit streaming kept receive on");
    property p_forced_rx; ack_wait_active || (collision_avoid_enable && csma_assess_active) |-> radio_rx_on; endproperty
    a_forced_rx: assert property (p_forced_rx) else $error("radio not forced into receive");
    property p_ctrl_bits;
        reg_wr && reg_addr == edrx_pkg::ADDR_RX_CTRL |=> {no_parse, append_link_quality, append_signal_strength,
            append_channel_format_rate, append_freq_offset} == {$past(reg_wdata[6]), $past(reg_wdata[4:1])};
    endproperty
    a_ctrl_bits: assert property (p_ctrl_bits) else $error("receive option outputs differ from write");
    property p_dec_flags;
        (decrypt_done_flag_set |-> decrypt_done && decrypt_ok) and (auth_tag_flag_set |-> decrypt_done && !decrypt_ok);
    endproperty
    a_dec_flags: assert property (p_dec_flags) else $error("security flag without matching outcome");
    property p_dec_start;
        decrypt_start_pulse |-> reg_wr && reg_addr == edrx_pkg::ADDR_RX_CTRL && reg_wdata[edrx_pkg::DECRYPT_BIT];
    endproperty
    a_dec_start: assert property (p_dec_start) else $error("security start without a write");
    property p_ed_suspend;
        reg_wr && reg_addr == edrx_pkg::ADDR_ED_CTRL && reg_wdata[edrx_pkg::ED_START_BIT] && !mode_write |=> rx_suspend;
    endproperty
    a_ed_suspend: assert property (p_ed_suspend) else $error("reception not suspended by measurement");
    property p_ed_nodone; $fell(rx_suspend) |-> !measure_done_flag_set; endproperty
    a_ed_nodone: assert property (p_ed_nodone) else $error("measurement end touched done flag");
    property p_ed_bound; susp_cnt <= 128 * ATOM_CYC + 2; endproperty
    a_ed_bound: assert property (p_ed_bound) else $error("measurement longer than longest scan");
    property p_rdata_hold; !$past(reg_rd) |-> $stable(reg_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without a read");
endmodule : edrx_core_props
bind edrx_core edrx_core_props #(.ATOM_CYC(ATOM_CYC), .SAMPLE_W(SAMPLE_W)) u_props (.*);

// File: energy_detect_rx_status_control_test.sv
// Register-level test of the energy-detect block
`timescale 1ns/1ns
module energy_detect_rx_status_control_test;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, signal_strength;
    logic [7:0] level = 8'h50;
    logic signal_valid;
    logic [1:0] transceiver_mode = 2'h0;
    logic mode_write = 1'b0, packet_arriving = 1'b0, collision_avoid_enable = 1'b0, csma_assess_active = 1'b0;
    logic ack_wait_active = 1'b0, decrypt_done = 1'b0, decrypt_ok = 1'b0;
    logic radio_rx_on, rx_abort, rx_suspend, no_parse, append_link_quality, append_signal_strength;
    logic append_channel_format_rate, append_freq_offset, decrypt_start_pulse, decrypt_done_flag_set;
    logic auth_tag_flag_set, measure_done_flag_set;
    logic done_seen = 1'b0, abort_seen = 1'b0, tag_seen = 1'b0;
    int failures = 0, checked = 0, cyc = 0, susp_cnt = 0;
    logic [7:0] rst_addr [6] = '{8'h15, 8'h2f, 8'h31, 8'h32, 8'h33, 8'h00};
    logic [7:0] rst_val [6] = '{8'h00, 8'h0c, 8'h0e, 8'h00, 8'h00, 8'h00};
    edrx_core #(.ATOM_CYC(4), .SAMPLE_W(8)) uut (.*);
    edrx_rf_model u_rf (.ref_clk(ref_clk), .level(level), .on(1'b1), .signal_strength(signal_strength),
        .signal_valid(signal_valid));
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (rx_suspend === 1'b1) susp_cnt <= susp_cnt + 1;
        if (measure_done_flag_set === 1'b1) done_seen <= 1'b1;
        if (rx_abort === 1'b1) abort_seen <= 1'b1;
        if (auth_tag_flag_set === 1'b1) tag_seen <= 1'b1;
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask : rchk
    // Polls instead of waiting a fixed time, so a stuck start bit ends as a mismatch
    task automatic wait_clear(input logic [7:0] a, input int b);
        logic [7:0] d;
        d = 8'hff;
        for (int i = 0; i < 300 && d[b] !== 1'b0; i++) rd(a, d);
    endtask : wait_clear
    task automatic set_mode(input logic [1:0] m);
        @(posedge ref_clk);
        transceiver_mode <= m;
        mode_write <= 1'b1;
        @(posedge ref_clk);
        mode_write <= 1'b0;
    endtask : set_mode
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 6; i++) rchk(rst_addr[i], rst_val[i]);
        wr(edrx_pkg::ADDR_ED_MEAN, 8'hff);
        rchk(edrx_pkg::ADDR_ED_MEAN, 8'h00);
        wr(edrx_pkg::ADDR_RX_CTRL, 8'h7f);
        rchk(edrx_pkg::ADDR_RX_CTRL, 8'h7e);
        chk({3'h0, no_parse, append_link_quality, append_signal_strength, append_channel_format_rate,
            append_freq_offset}, 8'h1f);
        @(posedge ref_clk);
        decrypt_done <= 1'b1;
        @(posedge ref_clk);
        decrypt_done <= 1'b0;
        rchk(edrx_pkg::ADDR_RX_CTRL, 8'h5e);
        chk({7'h0, tag_seen}, 8'h01);
        wr(edrx_pkg::ADDR_RX_CTRL, 8'h20);
        decrypt_ok <= 1'b1;
        decrypt_done <= 1'b1;
        #1;
        chk({7'h0, decrypt_done_flag_set}, 8'h01);
        @(posedge ref_clk);
        decrypt_done <= 1'b0;
        wr(edrx_pkg::ADDR_RX_CTRL, 8'h80);
        // Sampling mode: one atom into the peak register
        wr(edrx_pkg::ADDR_ED_CTRL, 8'h30);
        wait_clear(edrx_pkg::ADDR_ED_CTRL, 4);
        rchk(edrx_pkg::ADDR_ED_PEAK, 8'h50);
        rchk(edrx_pkg::ADDR_ED_CTRL, 8'h20);
        // Scan with length 1 must run sixteen atoms of four cycles
        level <= 8'h30;
        susp_cnt = 0;
        done_seen = 1'b0;
        wr(edrx_pkg::ADDR_ED_CTRL, 8'h11);
        wait_clear(edrx_pkg::ADDR_ED_CTRL, 4);
        chk({7'h0, susp_cnt >= 64 && susp_cnt <= 65}, 8'h01);
        rchk(edrx_pkg::ADDR_ED_MEAN, 8'h30);
        rchk(edrx_pkg::ADDR_ED_PEAK, 8'h30);
        chk({7'h0, done_seen}, 8'h00);
        // Aborts by clearing start and by dropping receive enable
        level <= 8'h70;
        wr(edrx_pkg::ADDR_ED_CTRL, 8'h1e);
        repeat (20) @(posedge ref_clk);
        wr(edrx_pkg::ADDR_ED_CTRL, 8'h0e);
        rchk(edrx_pkg::ADDR_ED_MEAN, 8'h30);
        chk({7'h0, rx_suspend}, 8'h00);
        wr(edrx_pkg::ADDR_ED_CTRL, 8'h1e);
        wr(edrx_pkg::ADDR_RX_CTRL, 8'h00);
        rchk(edrx_pkg::ADDR_ED_CTRL, 8'h0e);
        chk({6'h0, done_seen, rx_suspend}, 8'h00);
        wr(edrx_pkg::ADDR_RX_CTRL, 8'h80);
        // Assessment at the threshold boundary: 0x50 has upper six bits 0x14
        level <= 8'h50;
        for (int i = 0; i < 2; i++) begin
            done_seen = 1'b0;
            wr(edrx_pkg::ADDR_CCA_CTRL, 8'h53 + i[7:0]);
            rchk(edrx_pkg::ADDR_RX_SIDE, 8'h04 + i[7:0]);
            wait_clear(edrx_pkg::ADDR_CCA_CTRL, 6);
            rchk(edrx_pkg::ADDR_CCA_CTRL, {~i[0], 7'h13 + i[6:0]});
            chk({7'h0, done_seen}, 8'h01);
        end
        set_mode(edrx_pkg::MODE_TX_STREAM);
        rchk(edrx_pkg::ADDR_RX_CTRL, 8'h00);
        set_mode(edrx_pkg::MODE_RX_STREAM);
        rchk(edrx_pkg::ADDR_RX_CTRL, 8'h80);
        packet_arriving <= 1'b1;
        wr(edrx_pkg::ADDR_RX_CTRL, 8'h00);
        repeat (2) @(posedge ref_clk);
        chk({7'h0, abort_seen}, 8'h01);
        packet_arriving <= 1'b0;
        ack_wait_active <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk({7'h0, radio_rx_on}, 8'h01);
        ack_wait_active <= 1'b0;
        collision_avoid_enable <= 1'b1;
        csma_assess_active <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk({7'h0, radio_rx_on}, 8'h01);
        csma_assess_active <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk({7'h0, radio_rx_on}, 8'h00);
        give_verdict();
    end
endmodule : energy_detect_rx_status_control_test
